// ### pme_params.svh
// offsets, field positions, reset values and timing figures of the pm event block
`ifndef PME_PARAMS_SVH
`define PME_PARAMS_SVH

// register offsets from the programmable i/o base
`define PME_OFF_STATUS 16'h0000
`define PME_OFF_ENABLE 16'h0002

// field positions, shared by the status and enable registers; bus master is in the status register only
`define PME_BIT_TIMER 0
`define PME_BIT_BUSM 4
`define PME_BIT_NOTIFY 5
`define PME_BIT_BUTTON 8
`define PME_BIT_ALARM 10

// reset values
`define PME_ENABLE_RST 16'h0000
`define PME_STATUS_RST 16'h0000

// writable enable bits and implemented status bits; the rest are reserved and read zero
`define PME_ENABLE_MASK 16'h0521
`define PME_STATUS_MASK 16'h0531

// timer wrap figures: bit 22 of the 24-bit timer rises once per half period
`define PME_TIMER_BITS 24
`define PME_TIMER_WRAP_BIT 22
`define PME_TIMER_HALF_PERIOD_MS 2343.5

`endif

// ### pme_pkg.sv
// types shared by the pm event block
package pme_pkg;

  typedef logic [15:0] pme_word_t;

  // which register an i/o cycle reaches
  typedef enum logic [1:0] {
    PME_SEL_NONE,
    PME_SEL_STATUS,
    PME_SEL_ENABLE
  } pme_sel_e;

endpackage

// ### pme_sync.sv
// two-stage synchroniser for inputs from outside the mclk domain
`timescale 1ns/1ps
module pme_sync
  import pme_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // stage1 feeds only the second flop, so metastability never spreads
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// ### pme_event.sv
// pm event status and enable registers with interrupt and wake routing
`timescale 1ns/1ps
`include "pme_params.svh"

// Behaviour
// - set timer wrap flag when timer bit 22 rises
// - timer wrap flag therefore sets once per timer half period
// - timer wrap flag cleared by writing one; zero leaves it
// - enabled timer wrap raises os or firmware interrupt per route select
// - enable 0 no interrupt; route 0 firmware, route 1 os
// - alarm wake enable bit 10 cleared only by alarm reset, override or a write of zero
// - enabled alarm flag raises routed interrupt and wake; disabled neither
// - button enable bit 8 gates routed interrupt from button flag
// - button flag sets on press regardless of its enable
// - button press is always a wake source
// - notify enable bit 5 and notify flag raise os interrupt
// - enable register 16 bits, read/write, resets zero, reserved bits
// - enable bits split over core, resume and alarm wells
// - bus master flag also sets while any audio run bit is one
// - route select 0 sends timer, alarm and button events to firmware, 1 to os
module pme_event
  import pme_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic resume_rst_n,
  input wire logic alarm_well_reset_pin_n,
  input wire logic [15:0] pm_io_base,
  input wire logic [15:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [1:0] io_be,
  input wire logic [15:0] io_wdata,
  output logic [15:0] io_rdata,
  output logic io_hit,
  input wire logic timer_bit22,
  input wire logic power_button_n,
  input wire logic alarm_event,
  input wire logic button_override,
  input wire logic firmware_notify_req,
  input wire logic bus_master_req,
  input wire logic audio_in_channel_control,
  input wire logic audio_out_channel_control,
  input wire logic modem_channel_control,
  input wire logic mic_channel_control,
  input wire logic interrupt_route_select,
  output logic os_event_interrupt,
  output logic firmware_mgmt_interrupt,
  output logic wake_event
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte lanes of a write, expanded to a bit mask
  function automatic pme_word_t lane_mask(input logic [1:0] be);
    lane_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction

  // ----------------------------------------------------------------
  // pin inputs
  // ----------------------------------------------------------------
  logic [2:0] pins_sync;
  logic timer_s;
  logic button_s;
  logic alarm_s;
  logic timer_d;
  logic button_d;
  logic alarm_d;
  logic [1:0] settle;
  // edge detectors stay blind until sync and delay flops hold real levels;
  // a timer bit already high when reset lifts is no rise, at the cost of
  // losing a genuine edge in the first three cycles
  wire settled = (settle == 2'h3);
  wire [1:0] next_settle = settled ? settle : settle + 2'h1;

  // the timer runs on its own clock, so its bit is resynchronised here
  pme_sync #(.WIDTH(3)) u_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .async_in({timer_bit22, ~power_button_n, alarm_event}),
    .sync_out(pins_sync)
  );

  assign timer_s = pins_sync[2];
  assign button_s = pins_sync[1];
  assign alarm_s = pins_sync[0];

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      timer_d <= 1'b0;
      button_d <= 1'b0;
      alarm_d <= 1'b0;
      settle <= 2'h0;
    end else begin
      timer_d <= timer_s;
      button_d <= button_s;
      alarm_d <= alarm_s;
      settle <= next_settle;
    end
  end

  wire timer_rise = settled & timer_s & ~timer_d;
  wire button_rise = settled & button_s & ~button_d;
  wire alarm_rise = settled & alarm_s & ~alarm_d;
  wire audio_busy = audio_in_channel_control | audio_out_channel_control
                  | modem_channel_control | mic_channel_control;

  // ----------------------------------------------------------------
  // i/o decode
  // ----------------------------------------------------------------
  wire [15:0] rel_addr = io_addr - pm_io_base;
  wire hit_status = (rel_addr == `PME_OFF_STATUS);
  wire hit_enable = (rel_addr == `PME_OFF_ENABLE);
  pme_sel_e sel;
  assign sel = hit_status ? PME_SEL_STATUS
             : hit_enable ? PME_SEL_ENABLE : PME_SEL_NONE;
  wire pme_word_t wmask = lane_mask(io_be);
  wire pme_word_t wr_ones = io_wdata & wmask;
  wire wr_status = io_wr && (sel == PME_SEL_STATUS);
  wire wr_enable = io_wr && (sel == PME_SEL_ENABLE);
  wire pme_word_t clr = wr_status ? wr_ones : 16'h0000;

  // ----------------------------------------------------------------
  // enable register, split across three wells
  // ----------------------------------------------------------------
  logic timer_wrap_enable;
  logic firmware_notify_enable;
  logic button_event_enable;
  logic alarm_wake_enable;

  // core well: bits 7:0
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      timer_wrap_enable <= 1'(`PME_ENABLE_RST >> `PME_BIT_TIMER);
      firmware_notify_enable <= 1'b0;
    end else if (wr_enable && io_be[0]) begin
      timer_wrap_enable <= io_wdata[`PME_BIT_TIMER];
      firmware_notify_enable <= io_wdata[`PME_BIT_NOTIFY];
    end
  end

  // resume well: bits 8, 9 and 15:11
  always_ff @(posedge mclk or negedge resume_rst_n) begin
    if (!resume_rst_n) begin
      button_event_enable <= 1'b0;
    end else if (wr_enable && io_be[1]) begin
      button_event_enable <= io_wdata[`PME_BIT_BUTTON];
    end
  end

  // alarm well: bit 10 survives every reset but its own pin
  always_ff @(posedge mclk or negedge alarm_well_reset_pin_n) begin
    if (!alarm_well_reset_pin_n) begin
      alarm_wake_enable <= 1'b0;
    end else if (button_override) begin
      alarm_wake_enable <= 1'b0;
    end else if (wr_enable && io_be[1]) begin
      alarm_wake_enable <= io_wdata[`PME_BIT_ALARM];
    end
  end

  wire pme_word_t enable_view = (16'(timer_wrap_enable) << `PME_BIT_TIMER)
    | (16'(firmware_notify_enable) << `PME_BIT_NOTIFY)
    | (16'(button_event_enable) << `PME_BIT_BUTTON)
    | (16'(alarm_wake_enable) << `PME_BIT_ALARM);

  // ----------------------------------------------------------------
  // status flags: set wins over a clear in the same cycle
  // ----------------------------------------------------------------
  logic timer_wrap_flag;
  logic bus_master_activity_flag;
  logic firmware_notify_flag;
  logic button_press_flag;
  logic alarm_event_flag;

  wire next_timer_wrap_flag = timer_rise
    | (timer_wrap_flag & ~clr[`PME_BIT_TIMER]);
  wire next_bus_master_flag = bus_master_req | audio_busy
    | (bus_master_activity_flag & ~clr[`PME_BIT_BUSM]);
  wire next_notify_flag = firmware_notify_req
    | (firmware_notify_flag & ~clr[`PME_BIT_NOTIFY]);
  wire next_button_flag = button_rise
    | (button_press_flag & ~clr[`PME_BIT_BUTTON]
       & ~button_override);
  wire next_alarm_flag = alarm_rise
    | (alarm_event_flag & ~clr[`PME_BIT_ALARM]);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      timer_wrap_flag <= 1'b0;
      bus_master_activity_flag <= 1'b0;
      firmware_notify_flag <= 1'b0;
    end else begin
      timer_wrap_flag <= next_timer_wrap_flag;
      bus_master_activity_flag <= next_bus_master_flag;
      firmware_notify_flag <= next_notify_flag;
    end
  end

  // button and alarm flags live outside the core well
  always_ff @(posedge mclk or negedge resume_rst_n) begin
    if (!resume_rst_n) begin
      button_press_flag <= 1'b0;
      alarm_event_flag <= 1'b0;
    end else begin
      button_press_flag <= next_button_flag;
      alarm_event_flag <= next_alarm_flag;
    end
  end

  wire pme_word_t status_view = (16'(timer_wrap_flag) << `PME_BIT_TIMER)
    | (16'(bus_master_activity_flag) << `PME_BIT_BUSM)
    | (16'(firmware_notify_flag) << `PME_BIT_NOTIFY)
    | (16'(button_press_flag) << `PME_BIT_BUTTON)
    | (16'(alarm_event_flag) << `PME_BIT_ALARM);

  // ----------------------------------------------------------------
  // routing
  // ----------------------------------------------------------------
  // bus master activity is only reported, never routed to an interrupt
  wire timer_src = timer_wrap_flag & timer_wrap_enable;
  wire alarm_src = alarm_event_flag & alarm_wake_enable;
  wire button_src = button_press_flag & button_event_enable;
  wire notify_src = firmware_notify_flag & firmware_notify_enable;
  wire routed_any = timer_src | alarm_src | button_src;
  wire next_os_irq = (routed_any & interrupt_route_select)
    | notify_src;
  wire next_fw_irq = routed_any & ~interrupt_route_select;
  wire next_wake = button_press_flag | alarm_src;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      os_event_interrupt <= 1'b0;
      firmware_mgmt_interrupt <= 1'b0;
      wake_event <= 1'b0;
    end else begin
      os_event_interrupt <= next_os_irq;
      firmware_mgmt_interrupt <= next_fw_irq;
      wake_event <= next_wake;
    end
  end

  // ----------------------------------------------------------------
  // read data, one cycle after the read strobe
  // ----------------------------------------------------------------
  wire pme_word_t rd_mux = (sel == PME_SEL_STATUS) ? status_view
    : (sel == PME_SEL_ENABLE) ? enable_view : 16'h0000;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      io_rdata <= 16'h0000;
      io_hit <= 1'b0;
    end else begin
      io_rdata <= io_rd ? (rd_mux & wmask) : 16'h0000;
      io_hit <= (io_rd | io_wr) && (sel != PME_SEL_NONE);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n || !resume_rst_n || !alarm_well_reset_pin_n);

  sequence s_timer_rises;
    settled && !timer_s ##1 timer_s;
  endsequence

  sequence s_timer_clear;
    wr_status && io_be[0] && io_wdata[`PME_BIT_TIMER] && !timer_rise;
  endsequence

  a_timer_wrap_set: assert property (
    s_timer_rises |=> timer_wrap_flag)
    else $error("timer wrap flag missed a rise of timer bit");

  a_timer_w1c_clear: assert property (
    s_timer_clear |=> !timer_wrap_flag)
    else $error("timer wrap flag not cleared by writing one");

  a_timer_zero_keep: assert property (
    timer_wrap_flag && !(wr_status && io_be[0] && io_wdata[0])
    |=> timer_wrap_flag)
    else $error("timer wrap flag lost without a clearing write");

  a_timer_route_fw: assert property (
    timer_wrap_flag && timer_wrap_enable && !interrupt_route_select
    |=> firmware_mgmt_interrupt)
    else $error("timer wrap did not reach firmware interrupt");

  a_timer_route_os: assert property (
    timer_src && interrupt_route_select |=> os_event_interrupt)
    else $error("timer wrap did not reach os interrupt");

  a_no_source_quiet: assert property (
    !routed_any && !notify_src
    |=> !os_event_interrupt && !firmware_mgmt_interrupt)
    else $error("interrupt raised with no enabled flag set");

  a_button_always_set: assert property (
    button_rise && !button_override
    |=> button_press_flag ##1 wake_event)
    else $error("button press not flagged or not a wake source");

  a_button_gate: assert property (
    button_press_flag && !button_event_enable && !timer_src && !alarm_src
    && !notify_src |=> !os_event_interrupt && !firmware_mgmt_interrupt)
    else $error("disabled button flag raised an interrupt");

  a_notify_os: assert property (
    firmware_notify_flag && firmware_notify_enable
    |=> os_event_interrupt)
    else $error("notify flag and enable did not raise os interrupt");

  a_alarm_override: assert property (
    button_override |=> !alarm_wake_enable)
    else $error("override did not clear alarm wake enable");

  a_busm_audio: assert property (
    audio_busy |=> bus_master_activity_flag)
    else $error("audio run bit did not set bus master flag");

endmodule

// ### pme_event_tb.sv
// self-checking bench for the pm event status and enable block
`timescale 1ns/1ps
module testbench;
  import pme_pkg::*;
  localparam logic [15:0] BASE = 16'h0400;
  logic mclk = 1'b0;
  // {override_n, alarm well, resume well, core well}, all active low
  logic [3:0] ctl_n = 4'h8;
  // {notify, alarm, button, timer wrap}, active high here
  logic [3:0] evs = 4'h0;
  // {bus master request, mic, modem, audio out, audio in}
  logic [4:0] runv = 5'h00;
  logic route = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic io_rd = 1'b0;
  logic io_wr = 1'b0;
  logic [1:0] be = 2'h3;
  logic [15:0] io_wdata = 16'h0000;
  logic [15:0] io_rdata;
  logic io_hit;
  logic os_irq, fw_irq, wake;
  int err_total = 0;
  int total_checks = 0;

  always #2.5 mclk = ~mclk;

  pme_event dut_u (
    .mclk(mclk), .arst_n(ctl_n[0]), .resume_rst_n(ctl_n[1]),
    .alarm_well_reset_pin_n(ctl_n[2]), .pm_io_base(BASE),
    .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_be(be),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit),
    .timer_bit22(evs[0]), .power_button_n(~evs[1]),
    .alarm_event(evs[2]), .button_override(~ctl_n[3]),
    .firmware_notify_req(evs[3]), .bus_master_req(runv[4]),
    .audio_in_channel_control(runv[0]),
    .audio_out_channel_control(runv[1]),
    .modem_channel_control(runv[2]), .mic_channel_control(runv[3]),
    .interrupt_route_select(route), .os_event_interrupt(os_irq),
    .firmware_mgmt_interrupt(fw_irq), .wake_event(wake)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [15:0] off, input logic [15:0] exp,
                    input logic hit = 1'b1);
    @(posedge mclk);
    io_addr <= BASE + off;
    io_rd <= 1'b1;
    @(posedge mclk);
    io_rd <= 1'b0;
    #1;
    chk(io_rdata, exp);
    chk({15'h0000, io_hit}, {15'h0000, hit});
  endtask

  task automatic wr(input logic [15:0] off, input logic [15:0] d);
    @(posedge mclk);
    io_addr <= BASE + off;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge mclk);
    io_wr <= 1'b0;
  endtask

  // outputs move through sync flops, so poll them under a bound
  task automatic wait_out(input logic [2:0] exp);
    int n;
    n = 0;
    while ({os_irq, fw_irq, wake} !== exp && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk({13'h0000, os_irq, fw_irq, wake}, {13'h0000, exp});
    // a bound that ran out has just been counted as a mismatch
    if ({os_irq, fw_irq, wake} !== exp) report_and_stop();
  endtask

  // hold an event pin long enough to pass the synchronisers
  task automatic ev(input int k);
    @(posedge mclk);
    evs[k] <= 1'b1;
    repeat (8) @(posedge mclk);
    evs[k] <= 1'b0;
    repeat (8) @(posedge mclk);
    #1;
  endtask

  task automatic pulse_n(input int k);
    @(posedge mclk);
    ctl_n[k] <= 1'b0;
    repeat (3) @(posedge mclk);
    ctl_n[k] <= 1'b1;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge mclk);
    ctl_n <= 4'hf;
    rd(16'h0002, 16'h0000);
    rd(16'h0000, 16'h0000);
    wr(16'h0002, 16'hffff);
    rd(16'h0002, 16'h0521);
    rd(16'h0006, 16'h0000, 1'b0);
    // byte lanes: only enabled lanes read back or take write data
    be <= 2'h2;
    rd(16'h0002, 16'h0500);
    wr(16'h0002, 16'h0000);
    be <= 2'h3;
    rd(16'h0002, 16'h0021);
    wr(16'h0002, 16'h0000);
    // disabled timer wrap: flag only, write zero keeps it
    ev(0);
    wait_out(3'b000);
    rd(16'h0000, 16'h0001);
    wr(16'h0000, 16'h0000);
    rd(16'h0000, 16'h0001);
    wr(16'h0000, 16'h0001);
    rd(16'h0000, 16'h0000);
    for (int r = 0; r < 2; r++) begin
      route <= r[0];
      wr(16'h0002, 16'h0001);
      ev(0);
      wait_out(r == 1 ? 3'b100 : 3'b010);
      wr(16'h0000, 16'h0001);
      wait_out(3'b000);
    end
    // button wakes even while its interrupt is disabled
    wr(16'h0002, 16'h0000);
    ev(1);
    wait_out(3'b001);
    rd(16'h0000, 16'h0100);
    wr(16'h0002, 16'h0100);
    wait_out(3'b101);
    wr(16'h0000, 16'h0100);
    wait_out(3'b000);
    wr(16'h0002, 16'h0000);
    ev(2);
    wait_out(3'b000);
    rd(16'h0000, 16'h0400);
    wr(16'h0000, 16'h0400);
    wr(16'h0002, 16'h0400);
    ev(2);
    wait_out(3'b101);
    wr(16'h0000, 16'h0400);
    wait_out(3'b000);
    // notify goes to the os interrupt even with route at firmware
    route <= 1'b0;
    wr(16'h0002, 16'h0020);
    ev(3);
    wait_out(3'b100);
    wr(16'h0000, 16'h0020);
    wait_out(3'b000);
    for (int i = 0; i < 5; i++) begin
      runv <= 5'h01 << i;
      repeat (6) @(posedge mclk);
      runv <= 5'h00;
      rd(16'h0000, 16'h0010);
      wait_out(3'b000);
      wr(16'h0000, 16'h0010);
      rd(16'h0000, 16'h0000);
    end
    // resume and alarm wells keep their enable bits across a core reset, the alarm well across a resume reset
    wr(16'h0002, 16'h0521);
    pulse_n(0);
    rd(16'h0002, 16'h0500);
    pulse_n(1);
    rd(16'h0002, 16'h0400);
    pulse_n(3);
    rd(16'h0002, 16'h0000);
    wr(16'h0002, 16'h0400);
    pulse_n(2);
    rd(16'h0002, 16'h0000);
    report_and_stop();
  end
endmodule
